// ===== gstf_engine_model.sv
`default_nettype none
module gstf_engine_model (
  // clocking and request
  input wire logic clock,
  input wire logic sample_req,
  input wire logic [3:0] lag,
  // answer
  output logic sample_valid,
  output logic [13:0] sample_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r = 4'h0;  // cycles left before answering
  logic [13:0] n_r = 14'h0;  // answers given
  initial sample_valid = 1'b0;
  initial sample_data = 14'h0;
  // answer lag cycles after a request; idle data toggles so it never looks held
  always @(posedge clock) begin
    sample_valid <= 1'b0;
    sample_data <= ~sample_data;
    if (sample_req) cnt_r <= lag;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    if (cnt_r == 4'h1) begin
      sample_valid <= 1'b1;
      sample_data <= 14'h100 + n_r * 14'h25;
      n_r <= n_r + 14'h1;
    end
  end
endmodule : gstf_engine_model
`default_nettype wire

// ===== gstf_pkg.sv
`default_nettype none
package gstf_pkg;
  // register offsets
  localparam logic [7:0] GSTF_ADDR_AVG_CFG = 8'hb2;
  localparam logic [7:0] GSTF_ADDR_SLEEP_STATUS = 8'hb3;
  localparam logic [7:0] GSTF_ADDR_PERIOD = 8'hb4;
  localparam logic [7:0] GSTF_ADDR_MODE_CTRL = 8'hb5;
  localparam logic [7:0] GSTF_ADDR_SLEEP_CTRL = 8'hbc;
  // field positions
  localparam int GSTF_BIT_AVG_DEPTH = 5;
  localparam int GSTF_BIT_AVG_ENABLE = 4;
  localparam int GSTF_BIT_SLEEP_LATCHED = 1;
  localparam int GSTF_BIT_SLEEP_CLEAR = 0;
  localparam int GSTF_BIT_GESTURE_ACTIVE = 0;
  localparam int GSTF_BIT_SLEEP_ENABLE = 1;
  // reset values
  localparam logic [7:0] GSTF_PERIOD_RESET = 8'h0a;
  localparam logic [7:0] GSTF_AVG_CFG_RESET = 8'h00;
  // timing: one period step is 88 us
  localparam int GSTF_CLOCK_HZ = 50000000;
  localparam int GSTF_STEP_US = 88;
  localparam int GSTF_STEP_CYCLES = GSTF_STEP_US * (GSTF_CLOCK_HZ / 1000000);
  // averaging window
  localparam int GSTF_WIN_DEPTH = 4;
  typedef enum logic [1:0] {GSTF_IDLE, GSTF_COUNT, GSTF_WAIT} gstf_state_t;
endpackage : gstf_pkg
`default_nettype wire

// ===== gstf_sva.sv
`default_nettype none
module gstf_sva #(
  parameter int STEP_CYCLES = 4
) (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // engine, fifo and status
  input wire logic irq_event,
  input wire logic sample_req,
  input wire logic sample_valid,
  input wire logic fifo_push,
  input wire logic osc_run,
  input wire logic gesture_active_state
);
  logic [7:0] per_r;  // shadow of the period register
  logic se_r;  // shadow of the sleep-after-irq enable
  logic gv_r;  // gap counter valid since last request
  logic [15:0] gap_r;  // cycles since last request
  // host strobes only count while the clock enable lets the block run
  wire wr_per = clk_en && reg_wr && reg_addr == 8'hb4;
  wire clr = clk_en && reg_wr && reg_addr == 8'hbc && reg_wdata[0];
  // shadows follow host writes; a period write voids the gap
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      per_r <= 8'h0a;
      se_r <= 1'b0;
      gv_r <= 1'b0;
      gap_r <= 16'h0;
    end else begin
      if (wr_per) per_r <= reg_wdata;
      if (clk_en && reg_wr && reg_addr == 8'hb5) se_r <= reg_wdata[1];
      gap_r <= sample_req ? 16'h1 : gap_r + 16'h1;
      // a frozen cycle stretches the gap, so it voids the spacing check too
      gv_r <= (gv_r | sample_req) & gesture_active_state & osc_run & !wr_per & clk_en;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n || !clk_en);
  // mode entry: flag, then the first request
  sequence s_enter;
    gesture_active_state ##1 sample_req;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_period_read: assert property (reg_rd && reg_addr == 8'hb4 |=> reg_rdata == per_r)
    else $error("period readback wrong");
  a_sleep_enter: assert property (irq_event && se_r |=> !osc_run) else $error("no sleep on irq");
  a_sleep_hold: assert property (!osc_run && !clr |=> !osc_run) else $error("woke without clear");
  a_sleep_wake: assert property (!osc_run && clr && !irq_event |=> osc_run) else $error("clear ignored");
  a_awake_hold: assert property (osc_run && !(irq_event && se_r) |=> osc_run) else $error("slept wrongly");
  a_mode_entry: assert property (reg_wr && reg_addr == 8'hb5 && reg_wdata[0] && !gesture_active_state
    && osc_run && !irq_event |=> s_enter) else $error("mode entry late");
  a_req_gap: assert property (sample_req && gv_r |-> gap_r == STEP_CYCLES * (per_r + 1))
    else $error("request spacing wrong");
  a_req_idle: assert property (!gesture_active_state && !$past(gesture_active_state) |-> !sample_req)
    else $error("request outside mode");
  a_req_sleep: assert property (!osc_run && !$past(osc_run) |-> !sample_req) else $error("request asleep");
  a_push_src: assert property (fifo_push |-> $past(sample_valid) || $past(sample_valid, 2))
    else $error("push without sample");
  // a low clock enable must hold reg_rdata, osc_run, gesture_active_state, sample_req and fifo_push where they are
  a_freeze_hold: assert property (disable iff (!rst_n) !clk_en |=> $stable(reg_rdata) && $stable(osc_run)
    && $stable(gesture_active_state) && $stable(sample_req) && $stable(fifo_push))
    else $error("state moved while frozen");
endmodule : gstf_sva
bind gstf_top gstf_sva #(.STEP_CYCLES(STEP_CYCLES)) i_gstf_sva (.clock, .rst_n, .clk_en, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .irq_event, .sample_req, .sample_valid, .fifo_push, .osc_run,
  .gesture_active_state);
`default_nettype wire

// ===== gstf_tail_unused.sv
`default_nettype none
`default_nettype wire

// ===== gstf_top.sv
// What this block does
// - depth bit picks 2 or 4 samples
// - average only while enable bit 4 set
// - sliding window, one result per sample
// - sleep after irq sets flag, stops oscillator
// - clear bit drops flag, restarts oscillator
// - period paces sampling only in gesture mode
// - gesture mode runs engine, appends datasets
// - one sample per 88us times setting plus one
// - period resets to 0x0a
//
// Our own choice: the address-and-strobe port.
`default_nettype none
module gstf_top
  import gstf_pkg::*;
#(
  parameter int DATA_W = 14,
  parameter int STEP_CYCLES = gstf_pkg::GSTF_STEP_CYCLES
) (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // gesture engine side
  input wire logic gesture_exit,
  input wire logic irq_event,
  output logic sample_req,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_data,
  // towards the fifo
  output logic fifo_push,
  output logic [DATA_W-1:0] fifo_data,
  // oscillator and mode status
  output logic osc_run,
  output logic gesture_active_state
);
  import gstf_pkg::*;

  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);

  // configuration registers
  logic [7:0] period_r, period_nxt;
  logic gesture_avg_depth_r, gesture_avg_depth_nxt;
  logic gesture_avg_enable_r, gesture_avg_enable_nxt;
  logic sleep_after_irq_enable_r, sleep_after_irq_enable_nxt;
  logic sleep_latched_flag_r, sleep_latched_flag_nxt;
  logic mode_r, mode_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic sleep_latch_clear;

  // a write of 1 to the control bit is the clear strobe
  assign sleep_latch_clear = reg_wr && (reg_addr == GSTF_ADDR_SLEEP_CTRL) && reg_wdata[GSTF_BIT_SLEEP_CLEAR];

  // register writes, sleep latch and mode
  always_comb begin
    period_nxt = period_r;
    gesture_avg_depth_nxt = gesture_avg_depth_r;
    gesture_avg_enable_nxt = gesture_avg_enable_r;
    sleep_after_irq_enable_nxt = sleep_after_irq_enable_r;
    sleep_latched_flag_nxt = sleep_latched_flag_r;
    mode_nxt = mode_r;
    if (reg_wr) begin
      case (reg_addr)
        GSTF_ADDR_AVG_CFG: begin
          gesture_avg_depth_nxt = reg_wdata[GSTF_BIT_AVG_DEPTH];
          gesture_avg_enable_nxt = reg_wdata[GSTF_BIT_AVG_ENABLE];
        end
        GSTF_ADDR_PERIOD: begin
          period_nxt = reg_wdata;
        end
        GSTF_ADDR_MODE_CTRL: begin
          mode_nxt = reg_wdata[GSTF_BIT_GESTURE_ACTIVE];
          sleep_after_irq_enable_nxt = reg_wdata[GSTF_BIT_SLEEP_ENABLE];
        end
        default: begin
        end
      endcase
    end
    // engine signals exit at end of conversion
    if (gesture_exit) begin
      mode_nxt = 1'b0;
    end
    // clear drops the flag and restarts the oscillator
    if (sleep_latch_clear && sleep_latched_flag_r) begin
      sleep_latched_flag_nxt = 1'b0;
    end
    // a new interrupt wins over a clear in the same cycle
    if (irq_event && sleep_after_irq_enable_r) begin
      sleep_latched_flag_nxt = 1'b1;
    end
  end

  // read mux, data stands the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        GSTF_ADDR_AVG_CFG: begin
          rdata_nxt[GSTF_BIT_AVG_DEPTH] = gesture_avg_depth_r;
          rdata_nxt[GSTF_BIT_AVG_ENABLE] = gesture_avg_enable_r;
        end
        GSTF_ADDR_SLEEP_STATUS: begin
          rdata_nxt[GSTF_BIT_SLEEP_LATCHED] = sleep_latched_flag_r;
        end
        GSTF_ADDR_PERIOD: begin
          rdata_nxt = period_r;
        end
        GSTF_ADDR_MODE_CTRL: begin
          rdata_nxt[GSTF_BIT_GESTURE_ACTIVE] = mode_r;
          rdata_nxt[GSTF_BIT_SLEEP_ENABLE] = sleep_after_irq_enable_r;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // register the config block; read data stands one cycle, longer while the clock enable is low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      period_r <= GSTF_PERIOD_RESET;
      gesture_avg_depth_r <= GSTF_AVG_CFG_RESET[GSTF_BIT_AVG_DEPTH];
      gesture_avg_enable_r <= GSTF_AVG_CFG_RESET[GSTF_BIT_AVG_ENABLE];
      sleep_after_irq_enable_r <= 1'b0;
      sleep_latched_flag_r <= 1'b0;
      mode_r <= 1'b0;
      rdata_r <= 8'h00;
    end else if (clk_en) begin
      period_r <= period_nxt;
      gesture_avg_depth_r <= gesture_avg_depth_nxt;
      gesture_avg_enable_r <= gesture_avg_enable_nxt;
      sleep_after_irq_enable_r <= sleep_after_irq_enable_nxt;
      sleep_latched_flag_r <= sleep_latched_flag_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign gesture_active_state = mode_r;
  assign osc_run = ~sleep_latched_flag_r;

  // sample pacing state
  gstf_state_t state_r, state_nxt;
  logic [CNT_W-1:0] step_r, step_nxt;
  logic [7:0] slot_r, slot_nxt;
  logic req_r, req_nxt;
  logic pacing;

  // pace only in gesture mode with the oscillator running
  assign pacing = mode_r && !sleep_latched_flag_r;

  // period = 88us steps times setting plus one
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    slot_nxt = slot_r;
    req_nxt = 1'b0;
    case (state_r)
      GSTF_IDLE: begin
        step_nxt = '0;
        slot_nxt = 8'h00;
        if (pacing) begin
          req_nxt = 1'b1;
          state_nxt = GSTF_COUNT;
        end
      end
      GSTF_COUNT: begin
        if (!pacing) begin
          state_nxt = GSTF_IDLE;
        end else if (step_r == STEP_LAST) begin
          step_nxt = '0;
          if (slot_r >= period_r) begin
            slot_nxt = 8'h00;
            req_nxt = 1'b1;
          end else begin
            slot_nxt = slot_r + 8'h01;
          end
        end else begin
          step_nxt = step_r + CNT_W'(1);
        end
      end
      default: begin
        state_nxt = GSTF_IDLE;
      end
    endcase
  end

  // register the pacing state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= GSTF_IDLE;
      step_r <= '0;
      slot_r <= 8'h00;
      req_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      slot_r <= slot_nxt;
      req_r <= req_nxt;
    end
  end

  assign sample_req = req_r;

  // averaging window
  logic [DATA_W*GSTF_WIN_DEPTH-1:0] win_flat;
  logic pend_r, pend_nxt;
  logic push_r, push_nxt;
  logic [DATA_W-1:0] out_r, out_nxt;
  logic [DATA_W+1:0] sum;

  gstf_window #(
    .WIDTH(DATA_W),
    .DEPTH(GSTF_WIN_DEPTH)
  ) u_window (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr_en(sample_valid && pacing),
    .wr_data(sample_data),
    .rd_data(win_flat)
  );

  // sum of 2 or 4 newest entries; window slides every sample
  always_comb begin
    sum = (DATA_W+2)'(win_flat[0 +: DATA_W]) + (DATA_W+2)'(win_flat[DATA_W +: DATA_W]);
    if (gesture_avg_depth_r) begin
      sum = sum + (DATA_W+2)'(win_flat[2*DATA_W +: DATA_W]) + (DATA_W+2)'(win_flat[3*DATA_W +: DATA_W]);
    end
  end

  // push one result per sample, raw or averaged
  always_comb begin
    pend_nxt = sample_valid && pacing && gesture_avg_enable_r;
    push_nxt = pend_r;
    out_nxt = out_r;
    if (sample_valid && pacing && !gesture_avg_enable_r) begin
      push_nxt = 1'b1;
      out_nxt = sample_data;
    end else if (pend_r) begin
      out_nxt = gesture_avg_depth_r ? sum[DATA_W+1:2] : sum[DATA_W:1];
    end
  end

  // register result
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
      push_r <= 1'b0;
      out_r <= '0;
    end else if (clk_en) begin
      pend_r <= pend_nxt;
      push_r <= push_nxt;
      out_r <= out_nxt;
    end
  end

  assign fifo_push = push_r;
  assign fifo_data = out_r;
endmodule : gstf_top
`default_nettype wire

// ===== gstf_window.sv
`default_nettype none
// small memory of the most recent samples; read data registered
module gstf_window #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // clocking
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  // write side
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  // registered read: all entries, newest at index 0
  output logic [WIDTH*DEPTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  // shift in the new sample
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_en) begin
      mem_nxt[0] = wr_data;
      for (int i = 1; i < DEPTH; i++) begin
        mem_nxt[i] = mem_r[i-1];
      end
    end
  end
  // register entries
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end
  // flatten read data
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_rd
      assign rd_data[g*WIDTH +: WIDTH] = mem_r[g];
    end
  endgenerate
endmodule : gstf_window
`default_nettype wire

// ===== testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_n, reg_wr, reg_rd, gesture_exit, irq_event, sample_req, sample_valid;
  logic fifo_push, osc_run, mode, avg, dep, clk_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [13:0] sample_data, fifo_data;
  logic [3:0] lag;
  logic [15:0] w[4];  // expected window, newest first
  logic [15:0] exq[$];  // expected fifo words
  int failures, check_count, npush;
  gstf_top #(.STEP_CYCLES(4)) i_gstf_top (.clock, .rst_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .gesture_exit, .irq_event, .sample_req, .sample_valid,
    .sample_data, .fifo_push, .fifo_data, .osc_run, .gesture_active_state(mode));
  gstf_engine_model i_gstf_engine_model (.clock, .sample_req, .lag, .sample_valid, .sample_data);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(string nm, logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(nm, {8'h00, e}, {8'h00, reg_rdata});
  endtask : rc
  task automatic waitp(int n);
    int k;
    k = npush + n;
    repeat (900) if (npush < k) @(posedge clock);
    chk("push count", 16'h1, {15'h0, npush >= k});
  endtask : waitp
  task automatic pulse_exit_irq(logic x, logic q);
    @(posedge clock);
    gesture_exit <= x;
    irq_event <= q;
    @(posedge clock);
    gesture_exit <= 1'b0;
    irq_event <= 1'b0;
  endtask : pulse_exit_irq
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // scoreboard: window model per sample, compare each pushed word
  // samples only count in gesture mode with the oscillator running
  always @(posedge clock) begin
    if (sample_valid && mode && osc_run) begin
      w[3] = w[2];
      w[2] = w[1];
      w[1] = w[0];
      w[0] = {2'b00, sample_data};
      exq.push_back(!avg ? w[0] : dep ? (w[0] + w[1] + w[2] + w[3]) >> 2 : (w[0] + w[1]) >> 1);
    end
    if (fifo_push) begin
      npush++;
      chk("fifo_data", exq.pop_front(), {2'b00, fifo_data});
    end
  end
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    test_done();
  end
  initial begin
    logic [7:0] cfg[2];
    int n;
    cfg = '{8'h10, 8'h30};
    w = '{16'h0, 16'h0, 16'h0, 16'h0};
    {rst_n, reg_wr, reg_rd, gesture_exit, irq_event, avg, dep} = 7'h0;
    clk_en = 1'b1;
    {reg_addr, reg_wdata} = 16'h0;
    lag = 4'h1;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rc("period", 8'hb4, 8'h0a);
    rc("avg cfg", 8'hb2, 8'h00);
    rc("unmapped", 8'hbd, 8'h00);
    wr(8'hb3, 8'hff);
    rc("status ro", 8'hb3, 8'h00);
    // a write while the clock enable is low must not land
    @(posedge clock);
    clk_en <= 1'b0;
    wr(8'hb4, 8'h55);
    clk_en <= 1'b1;
    rc("period frozen", 8'hb4, 8'h0a);
    wr(8'hb4, 8'h02);
    rc("period", 8'hb4, 8'h02);
    // raw samples, prompt then slow engine
    wr(8'hb5, 8'h01);
    waitp(3);
    lag <= 4'h5;
    waitp(3);
    // each averaging depth after a mode exit
    for (int i = 0; i < 2; i++) begin
      pulse_exit_irq(1'b1, 1'b0);
      rc("mode off", 8'hb5, 8'h00);
      wr(8'hb2, cfg[i]);
      avg = 1'b1;
      dep = cfg[i][5];
      rc("avg cfg", 8'hb2, cfg[i]);
      wr(8'hb5, 8'h01);
      waitp(6);
    end
    // irq without sleep enable keeps running
    pulse_exit_irq(1'b1, 1'b0);
    pulse_exit_irq(1'b0, 1'b1);
    rc("status", 8'hb3, 8'h00);
    chk("osc_run", 16'h1, {15'h0, osc_run});
    // sleep after irq, mode requested while asleep
    wr(8'hb5, 8'h02);
    pulse_exit_irq(1'b0, 1'b1);
    rc("status", 8'hb3, 8'h02);
    chk("osc_run", 16'h0, {15'h0, osc_run});
    wr(8'hb5, 8'h03);
    n = npush;
    repeat (60) @(posedge clock);
    chk("pushes asleep", 16'h0, 16'(npush - n));
    wr(8'hbc, 8'h01);
    rc("status", 8'hb3, 8'h00);
    chk("osc_run", 16'h1, {15'h0, osc_run});
    waitp(2);
    test_done();
  end
endmodule : testbench
`default_nettype wire
